/* core/bst_map.vh */
`ifndef BST_MAP_VH
`define BST_MAP_VH

// ----------------------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------------------
`define BST_ST_W 4
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SHF_DR 4'h4
`define BST_ST_EX1_DR 4'h5
`define BST_ST_PAU_DR 4'h6
`define BST_ST_EX2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'hA
`define BST_ST_SHF_IR 4'hB
`define BST_ST_EX1_IR 4'hC
`define BST_ST_PAU_IR 4'hD
`define BST_ST_EX2_IR 4'hE
`define BST_ST_UPD_IR 4'hF

// ----------------------------------------------------------------------------
// Instruction codes
// ----------------------------------------------------------------------------
`define BST_IR_W 4
`define BST_OP_EXTEST 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDCODE 4'h2
`define BST_OP_CLAMP 4'h3
`define BST_OP_HIGHZ 4'h4
`define BST_OP_BYPASS 4'hF
`define BST_IR_CAPTURE 4'h1

// ----------------------------------------------------------------------------
// Identification word layout
// ----------------------------------------------------------------------------
`define BST_ID_W 32
`define BST_ID_VER_W 4
`define BST_ID_PART_W 16
`define BST_ID_MAKER_W 11
`define BST_ID_FIXED 1'h1

`endif

/* core/bst_cell_chain.v */
`timescale 1ns/1ns
`include "bst_map.vh"

module bst_cell_chain #(
  parameter NPINS = 8
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Chain control
  input wire cap_en,
  input wire shift_en,
  input wire update_en,
  input wire sdi,
  input wire drive_test,
  input wire force_highz,
  output wire sdo,
  // Pins and core
  input wire [NPINS-1:0] pin_in,
  input wire [NPINS-1:0] core_out,
  input wire [NPINS-1:0] core_oe_n,
  output reg [NPINS-1:0] pin_out,
  output reg [NPINS-1:0] pin_oe_n,
  output reg [NPINS-1:0] core_in
);

  reg [2*NPINS-1:0] pin_scan_chain_reg;
  reg [NPINS-1:0] upd_reg;
  reg [NPINS-1:0] pin_s1_reg;
  reg [NPINS-1:0] pin_s2_reg;
  reg [NPINS-1:0] pin_s3_reg;
  reg [NPINS-1:0] pin_lvl_reg;
  wire [2*NPINS:0] chain_ext;

  assign sdo = pin_scan_chain_reg[0];
  // Serial input sits one place above the last cell
  assign chain_ext = {sdi, pin_scan_chain_reg};

  genvar i;
  generate
    for (i = 0; i < NPINS; i = i + 1) begin : g_pin
      // --------------------------------------------------------------------
      // Pin input synchroniser and filtered level
      // --------------------------------------------------------------------
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pin_s1_reg[i] <= 1'h0;
          pin_s2_reg[i] <= 1'h0;
          pin_s3_reg[i] <= 1'h0;
          pin_lvl_reg[i] <= 1'h0;
        end else begin
          pin_s1_reg[i] <= pin_in[i];
          pin_s2_reg[i] <= pin_s1_reg[i];
          pin_s3_reg[i] <= pin_s2_reg[i];
          if (pin_s2_reg[i] == pin_s3_reg[i]) begin
            pin_lvl_reg[i] <= pin_s3_reg[i];
          end
        end
      end

      // --------------------------------------------------------------------
      // Two cells per pin: even index in cell, odd index out cell
      // --------------------------------------------------------------------
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pin_scan_chain_reg[2*i] <= 1'h0;
          pin_scan_chain_reg[2*i+1] <= 1'h0;
          upd_reg[i] <= 1'h0;
        end else begin
          if (cap_en) begin
            pin_scan_chain_reg[2*i] <= pin_lvl_reg[i];
            pin_scan_chain_reg[2*i+1] <= core_out[i];
          end else if (shift_en) begin
            pin_scan_chain_reg[2*i] <= pin_scan_chain_reg[2*i+1];
            pin_scan_chain_reg[2*i+1] <= chain_ext[2*i+2];
          end
          if (update_en) begin
            upd_reg[i] <= pin_scan_chain_reg[2*i+1];
          end
        end
      end

      // --------------------------------------------------------------------
      // Pin drive and core input path
      // --------------------------------------------------------------------
      always @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          pin_out[i] <= 1'h0;
          pin_oe_n[i] <= 1'h1;
          core_in[i] <= 1'h0;
        end else begin
          core_in[i] <= pin_lvl_reg[i];
          if (drive_test) begin
            pin_out[i] <= upd_reg[i];
            pin_oe_n[i] <= 1'h0;
          end else if (force_highz) begin
            pin_out[i] <= core_out[i];
            pin_oe_n[i] <= 1'h1;
          end else begin
            pin_out[i] <= core_out[i];
            pin_oe_n[i] <= core_oe_n[i];
          end
        end
      end
    end
  endgenerate

endmodule

/* core/bst_tap.v */
`timescale 1ns/1ns
`include "bst_map.vh"

module bst_tap #(
  parameter NPINS = 8,
  parameter [`BST_ID_VER_W-1:0] ID_VERSION = 4'h1,       // Arbitrary value
  parameter [`BST_ID_PART_W-1:0] ID_PART = 16'h1234,     // Arbitrary value
  parameter [`BST_ID_MAKER_W-1:0] ID_MAKER = 11'h055     // Arbitrary value
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Test port
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg tdo,
  output reg tdo_oe_n,
  // Bidirectional pins
  input wire [NPINS-1:0] pin_in,
  output wire [NPINS-1:0] pin_out,
  output wire [NPINS-1:0] pin_oe_n,
  // Core side
  input wire [NPINS-1:0] core_out,
  input wire [NPINS-1:0] core_oe_n,
  output wire [NPINS-1:0] core_in
);

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  reg tck_s1_reg;
  reg tck_s2_reg;
  reg tck_s3_reg;
  reg tck_lvl_reg;
  reg tms_s1_reg;
  reg tms_s2_reg;
  reg tms_s3_reg;
  reg tms_lvl_reg;
  reg tdi_s1_reg;
  reg tdi_s2_reg;
  reg tdi_s3_reg;
  reg tdi_lvl_reg;
  reg [`BST_ST_W-1:0] state_reg;
  reg [`BST_ST_W-1:0] state_next;
  reg [`BST_IR_W-1:0] ir_shift_reg;
  reg [`BST_IR_W-1:0] ir_reg;
  reg [`BST_ID_W-1:0] maker_part_version_word_reg;
  reg single_bit_passthrough_reg;
  reg sel_chain;
  reg sel_id;
  reg drive_test;
  reg force_highz;
  reg tdo_next;
  wire tck_stable;
  wire tck_rise;
  wire tck_fall;
  wire tms_now;
  wire tdi_now;
  wire chain_sdo;
  wire shifting;
  wire [`BST_ID_W-1:0] id_word;

  // --------------------------------------------------------------------------
  // Input synchronisers, a change counts once stages two and three agree
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tck_s1_reg <= 1'h0;
      tck_s2_reg <= 1'h0;
      tck_s3_reg <= 1'h0;
      tck_lvl_reg <= 1'h0;
      tms_s1_reg <= 1'h1;
      tms_s2_reg <= 1'h1;
      tms_s3_reg <= 1'h1;
      tms_lvl_reg <= 1'h1;
      tdi_s1_reg <= 1'h1;
      tdi_s2_reg <= 1'h1;
      tdi_s3_reg <= 1'h1;
      tdi_lvl_reg <= 1'h1;
    end else begin
      tck_s1_reg <= tck;
      tck_s2_reg <= tck_s1_reg;
      tck_s3_reg <= tck_s2_reg;
      tms_s1_reg <= tms;
      tms_s2_reg <= tms_s1_reg;
      tms_s3_reg <= tms_s2_reg;
      tdi_s1_reg <= tdi;
      tdi_s2_reg <= tdi_s1_reg;
      tdi_s3_reg <= tdi_s2_reg;
      if (tck_stable) begin
        tck_lvl_reg <= tck_s3_reg;
      end
      if (tms_s2_reg == tms_s3_reg) begin
        tms_lvl_reg <= tms_s3_reg;
      end
      if (tdi_s2_reg == tdi_s3_reg) begin
        tdi_lvl_reg <= tdi_s3_reg;
      end
    end
  end

  assign tck_stable = (tck_s2_reg == tck_s3_reg);
  assign tck_rise = tck_stable && tck_s3_reg && !tck_lvl_reg;
  assign tck_fall = tck_stable && !tck_s3_reg && tck_lvl_reg;
  // Levels settled before the clock edge is seen, as the tester must set up
  assign tms_now = (tms_s2_reg == tms_s3_reg) ? tms_s3_reg : tms_lvl_reg;
  assign tdi_now = (tdi_s2_reg == tdi_s3_reg) ? tdi_s3_reg : tdi_lvl_reg;

  // --------------------------------------------------------------------------
  // Sixteen-state controller
  // --------------------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      `BST_ST_RESET: begin
        state_next = tms_now ? `BST_ST_RESET : `BST_ST_IDLE;
      end
      `BST_ST_IDLE: begin
        state_next = tms_now ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      end
      `BST_ST_SEL_DR: begin
        state_next = tms_now ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
      end
      `BST_ST_CAP_DR: begin
        state_next = tms_now ? `BST_ST_EX1_DR : `BST_ST_SHF_DR;
      end
      `BST_ST_SHF_DR: begin
        state_next = tms_now ? `BST_ST_EX1_DR : `BST_ST_SHF_DR;
      end
      `BST_ST_EX1_DR: begin
        state_next = tms_now ? `BST_ST_UPD_DR : `BST_ST_PAU_DR;
      end
      `BST_ST_PAU_DR: begin
        state_next = tms_now ? `BST_ST_EX2_DR : `BST_ST_PAU_DR;
      end
      `BST_ST_EX2_DR: begin
        state_next = tms_now ? `BST_ST_UPD_DR : `BST_ST_SHF_DR;
      end
      `BST_ST_UPD_DR: begin
        state_next = tms_now ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      end
      `BST_ST_SEL_IR: begin
        state_next = tms_now ? `BST_ST_RESET : `BST_ST_CAP_IR;
      end
      `BST_ST_CAP_IR: begin
        state_next = tms_now ? `BST_ST_EX1_IR : `BST_ST_SHF_IR;
      end
      `BST_ST_SHF_IR: begin
        state_next = tms_now ? `BST_ST_EX1_IR : `BST_ST_SHF_IR;
      end
      `BST_ST_EX1_IR: begin
        state_next = tms_now ? `BST_ST_UPD_IR : `BST_ST_PAU_IR;
      end
      `BST_ST_PAU_IR: begin
        state_next = tms_now ? `BST_ST_EX2_IR : `BST_ST_PAU_IR;
      end
      `BST_ST_EX2_IR: begin
        state_next = tms_now ? `BST_ST_UPD_IR : `BST_ST_SHF_IR;
      end
      `BST_ST_UPD_IR: begin
        state_next = tms_now ? `BST_ST_SEL_DR : `BST_ST_IDLE;
      end
      default: begin
        state_next = `BST_ST_RESET;
      end
    endcase
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= `BST_ST_RESET;
    end else if (tck_rise) begin
      state_reg <= state_next;
    end
  end

  // --------------------------------------------------------------------------
  // Instruction register and decode
  // --------------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ir_shift_reg <= `BST_IR_CAPTURE;
      ir_reg <= `BST_OP_IDCODE;
    end else if (tck_rise) begin
      if (state_reg == `BST_ST_CAP_IR) begin
        ir_shift_reg <= `BST_IR_CAPTURE;
      end else if (state_reg == `BST_ST_SHF_IR) begin
        ir_shift_reg <= {tdi_now, ir_shift_reg[`BST_IR_W-1:1]};
      end
      if (state_reg == `BST_ST_RESET) begin
        ir_reg <= `BST_OP_IDCODE;
      end else if (state_reg == `BST_ST_UPD_IR) begin
        ir_reg <= ir_shift_reg;
      end
    end
  end

  // Unknown codes fall back to the passthrough path
  always @* begin
    sel_chain = 1'h0;
    sel_id = 1'h0;
    drive_test = 1'h0;
    force_highz = 1'h0;
    case (ir_reg)
      `BST_OP_EXTEST: begin
        sel_chain = 1'h1;
        drive_test = 1'h1;
      end
      `BST_OP_SAMPLE: begin
        sel_chain = 1'h1;
      end
      `BST_OP_IDCODE: begin
        sel_id = 1'h1;
      end
      `BST_OP_CLAMP: begin
        drive_test = 1'h1;
      end
      `BST_OP_HIGHZ: begin
        force_highz = 1'h1;
      end
      default: begin
        sel_chain = 1'h0;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // Identification word and passthrough bit
  // --------------------------------------------------------------------------
  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, `BST_ID_FIXED};

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      maker_part_version_word_reg <= {`BST_ID_W{1'h0}};
      single_bit_passthrough_reg <= 1'h0;
    end else if (tck_rise) begin
      if (state_reg == `BST_ST_CAP_DR) begin
        maker_part_version_word_reg <= id_word;
        single_bit_passthrough_reg <= 1'h0;
      end else if (state_reg == `BST_ST_SHF_DR) begin
        maker_part_version_word_reg <= {tdi_now, maker_part_version_word_reg[`BST_ID_W-1:1]};
        single_bit_passthrough_reg <= tdi_now;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin chain
  // --------------------------------------------------------------------------
  bst_cell_chain #(
    .NPINS(NPINS)
  ) u_chain (
    .mclk(mclk),
    .arst_n(arst_n),
    .cap_en(tck_rise && sel_chain && (state_reg == `BST_ST_CAP_DR)),
    .shift_en(tck_rise && sel_chain && (state_reg == `BST_ST_SHF_DR)),
    .update_en(tck_rise && sel_chain && (state_reg == `BST_ST_UPD_DR)),
    .sdi(tdi_now),
    .drive_test(drive_test),
    .force_highz(force_highz),
    .sdo(chain_sdo),
    .pin_in(pin_in),
    .core_out(core_out),
    .core_oe_n(core_oe_n),
    .pin_out(pin_out),
    .pin_oe_n(pin_oe_n),
    .core_in(core_in)
  );

  // --------------------------------------------------------------------------
  // Serial output on the falling test-clock edge
  // --------------------------------------------------------------------------
  assign shifting = (state_reg == `BST_ST_SHF_DR) || (state_reg == `BST_ST_SHF_IR);

  always @* begin
    if (state_reg == `BST_ST_SHF_IR) begin
      tdo_next = ir_shift_reg[0];
    end else if (sel_chain) begin
      tdo_next = chain_sdo;
    end else if (sel_id) begin
      tdo_next = maker_part_version_word_reg[0];
    end else begin
      tdo_next = single_bit_passthrough_reg;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tdo <= 1'h0;
      tdo_oe_n <= 1'h1;
    end else if (tck_fall) begin
      tdo <= tdo_next;
      tdo_oe_n <= !shifting;
    end
  end

endmodule

/* verification/bst_tap_properties.sv */
`timescale 1ns/1ns

module bst_tap_properties #(
  parameter NPINS = 8
) (
  // Clock and reset
  input wire mclk,
  input wire arst_n,
  // Test port
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire tdo,
  input wire tdo_oe_n,
  // Pins and core
  input wire [NPINS-1:0] pin_in,
  input wire [NPINS-1:0] pin_out,
  input wire [NPINS-1:0] pin_oe_n,
  input wire [NPINS-1:0] core_out,
  input wire [NPINS-1:0] core_oe_n,
  input wire [NPINS-1:0] core_in
);
  reg tck_last_reg;
  reg tms_rise_reg;
  reg [3:0] fall_age_reg;
  reg [3:0] rise_age_reg;

  // ----------------------------------------------------------------------------
  // Ages of the last test-clock edges, mode level at the last rise
  // ----------------------------------------------------------------------------
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tck_last_reg <= 1'h0;
      tms_rise_reg <= 1'h1;
      fall_age_reg <= 4'hF;
      rise_age_reg <= 4'hF;
    end else begin
      tck_last_reg <= tck;
      fall_age_reg <= (tck_last_reg && !tck) ? 4'h0 : (fall_age_reg == 4'hF) ? fall_age_reg : fall_age_reg + 4'h1;
      rise_age_reg <= (!tck_last_reg && tck) ? 4'h0 : (rise_age_reg == 4'hF) ? rise_age_reg : rise_age_reg + 4'h1;
      if (!tck_last_reg && tck)
        tms_rise_reg <= tms;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_tdo_timing: assert property ($changed(tdo) |-> fall_age_reg >= 4'h1 && fall_age_reg <= 4'h8)
    else $error("tdo moved away from a test clock fall");
  a_oe_timing: assert property ($changed(tdo_oe_n) |-> fall_age_reg >= 4'h1 && fall_age_reg <= 4'h8)
    else $error("tdo enable moved away from a test clock fall");
  a_oe_enter: assert property ($fell(tdo_oe_n) |-> !tms_rise_reg)
    else $error("tdo driven without entering a shift state");
  a_oe_leave: assert property ($rose(tdo_oe_n) |-> tms_rise_reg)
    else $error("tdo released without leaving a shift state");
  a_core_clean: assert property ($stable(pin_in) [*8] |-> core_in == pin_in)
    else $error("core input differs from settled pin level");
  a_pin_cause: assert property ($changed(pin_out) |-> rise_age_reg <= 4'h9 ||
      $past(core_out) != $past(core_out, 2) || $past(core_out, 2) != $past(core_out, 3))
    else $error("pin value changed without a cause");
  a_pinoe_cause: assert property ($changed(pin_oe_n) |-> rise_age_reg <= 4'h9 ||
      $past(core_oe_n) != $past(core_oe_n, 2) || $past(core_oe_n, 2) != $past(core_oe_n, 3))
    else $error("pin enable changed without a cause");
  a_pinoe_modes: assert property (pin_oe_n == $past(core_oe_n) || pin_oe_n == {NPINS{1'h0}} ||
      pin_oe_n == {NPINS{1'h1}})
    else $error("pin enables neither core nor forced");
  a_reset_float: assert property ($rose(arst_n) |-> tdo_oe_n && !tdo)
    else $error("tdo not floating after reset");
endmodule

bind bst_tap bst_tap_properties #(.NPINS(NPINS)) u_props (.mclk(mclk), .arst_n(arst_n), .tck(tck),
  .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .core_out(core_out), .core_oe_n(core_oe_n), .core_in(core_in));

/* verification/bst_tester.sv */
`timescale 1ns/1ns

module bst_tester (
  // Test port towards the device
  output reg tck,
  output reg tms,
  output reg tdi,
  input wire tdo,
  input wire tdo_oe_n,
  // Frame alignment
  input wire mclk
);
  reg o_x;
  reg oe_x;

  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end

  // One 320 ns period: levels set at the fall, output taken just before the next fall
  task cyc(input reg m, input reg d, output reg o, output reg oe);
    begin
      tms = m;
      tdi = d;
      #160;
      tck = 1'h1;
      #120;
      // A released line reads as the inverse of its last driven bit
      o = tdo_oe_n ? !tdo : tdo;
      oe = tdo_oe_n;
      #40;
      tck = 1'h0;
    end
  endtask

  task mv(input reg m);
    begin
      cyc(m, ~tdi, o_x, oe_x);
    end
  endtask

  // From idle: walk to a shift state, move n bits, update, back to idle
  task scan(input reg ir, input integer n, input reg [31:0] din, output reg [31:0] dout,
            output reg oe_shift, output reg oe_after);
    integer i;
    reg o;
    reg oe;
    begin
      @(negedge mclk);
      dout = 32'h0;
      oe_shift = 1'h0;
      mv(1'h1);
      if (ir)
        mv(1'h1);
      mv(1'h0);
      mv(1'h0);
      for (i = 0; i < n; i = i + 1) begin
        cyc(i == n - 1, din[i], o, oe);
        dout[i] = o;
        oe_shift = oe_shift | oe;
      end
      cyc(1'h1, ~tdi, o, oe_after);
      mv(1'h0);
    end
  endtask

  // As scan, but parks in pause between two halves of n bits each
  task scan_pause(input reg ir, input integer n, input reg [31:0] din, output reg [31:0] dout,
                  output reg oe_pause);
    integer i;
    reg o;
    reg oe;
    begin
      @(negedge mclk);
      dout = 32'h0;
      mv(1'h1);
      if (ir)
        mv(1'h1);
      mv(1'h0);
      mv(1'h0);
      for (i = 0; i < 2 * n; i = i + 1) begin
        cyc(i == n - 1 || i == 2 * n - 1, din[i], o, oe);
        dout[i] = o;
        if (i == n - 1) begin
          cyc(1'h0, ~tdi, o, oe);
          cyc(1'h1, ~tdi, o, oe_pause);
          cyc(1'h0, ~tdi, o, oe);
        end
      end
      cyc(1'h1, ~tdi, o, oe);
      mv(1'h0);
    end
  endtask

  // Five rises with mode high, then idle
  task tlr;
    begin
      @(negedge mclk);
      repeat (5) mv(1'h1);
      mv(1'h0);
    end
  endtask
endmodule

/* verification/bst_tap_tb.sv */
`timescale 1ns/1ns
`include "bst_map.vh"

`define CHK(got, exp) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) begin \
      num_errors = num_errors + 1; \
      $display("BAD at %0t got %0h expected %0h", $time, (got), (exp)); \
    end \
  end

module bst_tap_tb;
  localparam NPINS = 8;
  localparam [31:0] ID_WORD = {4'h1, 16'h1234, 11'h055, `BST_ID_FIXED};
  localparam [15:0] PRE = 16'hC5A3;
  reg mclk;
  reg arst_n;
  reg [7:0] pin_in, core_out, core_oe_n, pv;
  wire [7:0] pin_out, pin_oe_n, core_in;
  wire tck, tms, tdi, tdo, tdo_oe_n;
  reg [31:0] dout;
  reg [15:0] exp16;
  reg [3:0] code;
  reg oe_s, oe_a;
  integer num_errors, check_count, i, k;

  bst_tap #(.NPINS(NPINS), .ID_VERSION(4'h1), .ID_PART(16'h1234), .ID_MAKER(11'h055)) dut (
    .mclk(mclk), .arst_n(arst_n), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .core_out(core_out),
    .core_oe_n(core_oe_n), .core_in(core_in));
  bst_tester tester (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n), .mclk(mclk));

  initial begin
    mclk = 1'h0;
    forever #20 mclk = ~mclk;
  end

  task complete_run;
    begin
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task load_ir(input reg [3:0] c);
    begin
      tester.scan(1'h1, 4, {28'h0, c}, dout, oe_s, oe_a);
      `CHK(dout[3:0], `BST_IR_CAPTURE)
    end
  endtask

  task t_idcode;
    begin
      `CHK(tdo_oe_n, 1'h1)
      tester.scan(1'h0, 32, 32'h0, dout, oe_s, oe_a);
      `CHK(dout, ID_WORD)
      `CHK(dout[0], `BST_ID_FIXED)
      `CHK({oe_s, oe_a}, 2'h1)
      $display("test idcode done");
    end
  endtask

  task t_bypass;
    begin
      for (k = 0; k < 2; k = k + 1) begin
        code = (k == 0) ? `BST_OP_BYPASS : 4'h5;
        load_ir(code);
        tester.scan(1'h0, 8, 32'hB4, dout, oe_s, oe_a);
        `CHK(dout[7:0], 8'h68)
      end
      $display("test bypass done");
    end
  endtask

  task t_sample;
    begin
      @(negedge mclk);
      core_out = 8'h3C;
      core_oe_n = 8'h0F;
      pin_in = 8'h5A;
      repeat (10) @(negedge mclk);
      `CHK(pin_out, core_out)
      `CHK(pin_oe_n, core_oe_n)
      load_ir(`BST_OP_SAMPLE);
      tester.scan(1'h0, 16, {16'h0, PRE}, dout, oe_s, oe_a);
      for (i = 0; i < NPINS; i = i + 1) begin
        exp16[2*i] = pin_in[i];
        exp16[2*i+1] = core_out[i];
        pv[i] = PRE[2*i+1];
      end
      `CHK(dout[15:0], exp16)
      `CHK(core_in, pin_in)
      `CHK(pin_out, core_out)
      $display("test sample done");
    end
  endtask

  task t_modes;
    begin
      for (k = 0; k < 3; k = k + 1) begin
        code = (k == 0) ? `BST_OP_EXTEST : (k == 1) ? `BST_OP_CLAMP : `BST_OP_HIGHZ;
        load_ir(code);
        repeat (4) @(negedge mclk);
        `CHK(pin_oe_n, (k == 2) ? 8'hFF : 8'h00)
        if (k < 2)
          `CHK(pin_out, pv)
        `CHK(core_in, pin_in)
        tester.scan(1'h0, 16, {16'h0, PRE}, dout, oe_s, oe_a);
        `CHK(dout[15:0], (k == 0) ? exp16 : {PRE[14:0], 1'h0})
      end
      $display("test modes done");
    end
  endtask

  task t_tlr;
    begin
      tester.tlr;
      repeat (4) @(negedge mclk);
      `CHK(pin_oe_n, core_oe_n)
      `CHK(pin_out, core_out)
      t_idcode;
      $display("test reset walk done");
    end
  endtask

  task t_pause;
    begin
      tester.scan_pause(1'h0, 16, 32'h0, dout, oe_s);
      `CHK(dout, ID_WORD)
      `CHK(oe_s, 1'h1)
      tester.scan_pause(1'h1, 2, {28'h0, `BST_OP_BYPASS}, dout, oe_s);
      `CHK(dout[3:0], `BST_IR_CAPTURE)
      `CHK(oe_s, 1'h1)
      tester.scan(1'h0, 8, 32'hB4, dout, oe_s, oe_a);
      `CHK(dout[7:0], 8'h68)
      $display("test pause done");
    end
  endtask

  initial begin
    #1000000;
    num_errors = num_errors + 1;
    complete_run;
  end

  initial begin
    num_errors = 0;
    check_count = 0;
    arst_n = 1'h0;
    pin_in = 8'hA5;
    core_out = 8'h00;
    core_oe_n = 8'hFF;
    repeat (10) @(negedge mclk);
    arst_n = 1'h1;
    repeat (4) @(negedge mclk);
    tester.mv(1'h0);
    t_idcode;
    t_bypass;
    t_sample;
    t_modes;
    t_tlr;
    t_pause;
    complete_run;
  end
endmodule
